// file: rtl/tsw_conn_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module tsw_conn_ctrl #(
	parameter int BUF_DEPTH = 2 // output buffer entries, power of two
) (
	// clock and reset
	input  wire logic                        ref_clk,
	input  wire logic                        nrst,
	// host parallel port
	input  wire logic                        host_cs_n,
	input  wire logic                        host_ds_n,
	input  wire logic                        host_rw,
	input  wire logic [tsw_pkg::HA_W-1:0]    host_addr,
	input  wire logic [tsw_pkg::HD_W-1:0]    host_data_in,
	output logic      [tsw_pkg::HD_W-1:0]    host_data_out,
	output logic                             host_data_oe,
	output logic                             host_ack_n,
	// input channel bytes
	input  wire logic                        frame_start,
	input  wire logic                        in_valid,
	input  wire logic [tsw_pkg::ST_W-1:0]    in_stream,
	input  wire logic [tsw_pkg::CH_W-1:0]    in_channel,
	input  wire logic [tsw_pkg::BYTE_W-1:0]  in_byte,
	// output channel requests
	input  wire logic                        req_valid,
	output logic                             req_ready,
	input  wire logic [tsw_pkg::ST_W-1:0]    req_stream,
	input  wire logic [tsw_pkg::CH_W-1:0]    req_channel,
	// output channel bytes
	output logic                             out_valid,
	input  wire logic                        out_ready,
	output logic [tsw_pkg::BYTE_W-1:0]       out_byte,
	output logic                             out_drive
);
	import tsw_pkg::*;
	localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
	localparam logic [PW:0] BUF_FULL = (PW+1)'(BUF_DEPTH);

	tsw_state_e state_reg;                       // sequencer state
	tsw_state_e state_next;
	logic [PIN_W-1:0] pin_s1_reg;                // pin synchroniser
	logic [PIN_W-1:0] pin_s2_reg;
	logic [PIN_W-1:0] pin_s3_reg;
	logic             strobe_on_q_reg;           // strobe seen last cycle
	logic             cs_n_q, ds_n_q, rw_q;      // synchronised pins
	logic [HA_W-1:0]  addr_q;
	logic [HD_W-1:0]  wdata_q;
	logic             strobe_on, strobe_off, host_go;
	logic [HD_W-1:0]  rdata_reg;                 // host read data
	logic             rd_reg;                    // current access reads
	logic [CTRL_W-1:0]   ctrl_reg;               // select and delay enable
	logic                ims_reg;                // global receive enable
	logic [SOCR_W-1:0]   socr_reg [STREAMS];     // stream output control
	logic [CH_W-1:0]     brsr_reg [STREAMS];     // test start channel
	logic [BRLR_W-1:0]   brlr_reg [STREAMS];     // test window length
	logic [1:0]          brcr_reg [STREAMS];     // test control
	logic [HD_W-1:0]     err_reg  [STREAMS];     // test error count
	logic [PRBS_W-1:0]   prbs_reg [STREAMS];     // expected pattern state
	logic                bank_reg;               // frame bank being written
	logic [ST_W-1:0]     wk_stream_reg;          // request in progress
	logic [CH_W-1:0]     wk_chan_reg;
	logic [HD_W-1:0]     cml_keep_reg, cmh_keep_reg;
	logic [BYTE_W-1:0]   wk_byte_reg;
	logic                wk_drive_reg;
	logic [BYTE_W:0]     buf_mem [BUF_DEPTH];    // {drive, byte}
	logic [PW-1:0]       wr_ptr_reg, rd_ptr_reg;
	logic [PW:0]         count_reg;
	// decode results
	logic mem_space, h_ok, h_wait, host_take, host_mem_wr, host_reg_wr;
	logic [1:0]      sel;
	logic [ST_W-1:0] h_stream, idx;
	logic [CM_AW-1:0] h_addr;
	logic hit_ctrl, hit_ims, hit_socr, hit_brsr, hit_brlr, hit_brcr;
	logic [HD_W-1:0] reg_rdata;
	logic req_fire, cm_on, cm_switch, use_var, buf_space, push, pop;
	logic ber_cmp;
	logic [8:0]  ber_off, ber_cap, ber_len;
	logic [22:0] ber_step;
	logic [16:0] ber_sum;

	tsw_mem_if #(.AW(CM_AW), .DW(HD_W))   cml_if ();
	tsw_mem_if #(.AW(CM_AW), .DW(HD_W))   cmh_if ();
	tsw_mem_if #(.AW(DM_AW), .DW(BYTE_W)) dm_if ();

	tsw_mem #(.AW(CM_AW), .DW(HD_W)) u_cml (
		.ref_clk (ref_clk), .nrst (nrst), .port (cml_if.mem));
	tsw_mem #(.AW(CM_AW), .DW(HD_W)) u_cmh (
		.ref_clk (ref_clk), .nrst (nrst), .port (cmh_if.mem));
	tsw_mem #(.AW(DM_AW), .DW(BYTE_W)) u_dm (
		.ref_clk (ref_clk), .nrst (nrst), .port (dm_if.mem));

	// three flops on every host pin; only stages two and three are read
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			pin_s1_reg <= '1;
			pin_s2_reg <= '1;
			pin_s3_reg <= '1;
			strobe_on_q_reg <= 1'b0;
		end else begin
			pin_s1_reg <= {host_cs_n, host_ds_n, host_rw, host_addr,
				host_data_in};
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			strobe_on_q_reg <= strobe_on;
		end
	end

	assign {cs_n_q, ds_n_q, rw_q, addr_q, wdata_q} = pin_s3_reg;
	// strobe counts once stages two and three agree
	assign strobe_on = !pin_s2_reg[PIN_W-1] && !pin_s2_reg[PIN_W-2]
		&& !cs_n_q && !ds_n_q;
	assign strobe_off = (pin_s2_reg[PIN_W-1] && cs_n_q)
		|| (pin_s2_reg[PIN_W-2] && ds_n_q);
	// one more cycle so address and data have settled too
	assign host_go = strobe_on && strobe_on_q_reg;

	// host address decode
	always_comb begin
		mem_space = addr_q[MEM_SPACE_BIT];
		sel = ctrl_reg[CTRL_SEL_LSB +: 2];
		h_stream = addr_q[ADDR_ST_LSB +: ST_W];
		h_addr = {h_stream, addr_q[CH_W-1:0]};
		idx = addr_q[ST_W-1:0];
		h_ok = !addr_q[ADDR_ST_HI] && (sel != 2'h3)
			&& chan_ok(socr_reg[h_stream][SOCR_RATE +: 4],
			addr_q[CH_W-1:0]);
		// a host write to data memory waits for a free write port
		h_wait = mem_space && !rw_q && (sel == SEL_DM) && in_valid;
		host_take = (state_reg == ST_IDLE) && host_go && !h_wait;
		host_mem_wr = host_take && mem_space && !rw_q && h_ok;
		host_reg_wr = host_take && !mem_space && !rw_q;
		hit_ctrl = 1'b0;
		hit_ims = 1'b0;
		hit_socr = 1'b0;
		hit_brsr = 1'b0;
		hit_brlr = 1'b0;
		hit_brcr = 1'b0;
		reg_rdata = '0; // unmapped registers read zero
		if (addr_q == REG_CTRL) begin
			hit_ctrl = 1'b1;
			reg_rdata = HD_W'(ctrl_reg);
		end else if (addr_q == REG_IMS) begin
			hit_ims = 1'b1;
			reg_rdata = HD_W'(ims_reg);
		end else if ((addr_q & ~IDX_MASK) == REG_SOCR_BASE) begin
			hit_socr = 1'b1;
			reg_rdata = HD_W'(socr_reg[idx]);
		end else if ((addr_q & ~IDX_MASK) == REG_BRSR_BASE) begin
			hit_brsr = 1'b1;
			reg_rdata = HD_W'(brsr_reg[idx]);
		end else if ((addr_q & ~IDX_MASK) == REG_BRLR_BASE) begin
			hit_brlr = 1'b1;
			reg_rdata = HD_W'(brlr_reg[idx]);
		end else if ((addr_q & ~IDX_MASK) == REG_BRCR_BASE) begin
			hit_brcr = 1'b1;
			reg_rdata = HD_W'(brcr_reg[idx]);
		end else if ((addr_q & ~IDX_MASK) == REG_BRER_BASE) begin
			reg_rdata = err_reg[idx];
		end
	end

	// software registers
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			ctrl_reg <= '0;
			ims_reg <= 1'b0;
			for (int i = 0; i < STREAMS; i++) begin
				socr_reg[i] <= '0;
				brsr_reg[i] <= '0;
				brlr_reg[i] <= '0;
				brcr_reg[i] <= '0;
			end
		end else if (host_reg_wr) begin
			if (hit_ctrl)
				ctrl_reg <= wdata_q[CTRL_W-1:0];
			if (hit_ims)
				ims_reg <= wdata_q[IMS_RXEN];
			if (hit_socr)
				socr_reg[idx] <= wdata_q[SOCR_W-1:0];
			if (hit_brsr)
				brsr_reg[idx] <= wdata_q[CH_W-1:0];
			if (hit_brlr)
				brlr_reg[idx] <= wdata_q[BRLR_W-1:0];
			if (hit_brcr)
				brcr_reg[idx] <= wdata_q[1:0];
		end
	end

	// datapath request decode from the fetched entries
	always_comb begin
		req_fire = req_valid && req_ready;
		cm_on = chan_ok(socr_reg[wk_stream_reg][SOCR_RATE +: 4],
			wk_chan_reg);
		cm_switch = cm_on && !cml_if.rdata[CML_MODE];
		// variable delay only honoured once software enabled it
		use_var = cml_if.rdata[CML_VC] && ctrl_reg[CTRL_VARIABLE_DELAY_ENABLE];
		buf_space = count_reg != BUF_FULL;
	end

	assign req_ready = (state_reg == ST_IDLE) && !host_go && buf_space;

	// memory port steering
	always_comb begin
		cml_if.re = state_reg == ST_IDLE;
		cmh_if.re = state_reg == ST_IDLE;
		cml_if.raddr = host_go ? h_addr : {req_stream, req_channel};
		cmh_if.raddr = cml_if.raddr;
		cml_if.we = host_mem_wr && (sel == SEL_CML);
		cmh_if.we = host_mem_wr && (sel == SEL_CMH);
		cml_if.waddr = h_addr;
		cmh_if.waddr = h_addr;
		cml_if.wdata = wdata_q;
		cmh_if.wdata = wdata_q;
		dm_if.re = (state_reg == ST_IDLE) || (state_reg == ST_CMRD);
		if (state_reg == ST_CMRD)
			dm_if.raddr = {use_var ? bank_reg : !bank_reg,
				cml_if.rdata[CML_SSA +: ST_W],
				cml_if.rdata[CML_SCA +: CH_W]};
		else
			dm_if.raddr = {!bank_reg, h_addr};
		dm_if.we = in_valid || (host_mem_wr && (sel == SEL_DM));
		dm_if.waddr = in_valid ? {bank_reg, in_stream, in_channel}
			: {!bank_reg, h_addr};
		dm_if.wdata = in_valid ? in_byte : wdata_q[BYTE_W-1:0];
	end

	// sequencer: host first, then one output request at a time
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (host_take)
					state_next = (mem_space && rw_q && h_ok) ? ST_HRD
						: ST_ACK;
				else if (req_fire)
					state_next = ST_CMRD;
			end
			ST_HRD: state_next = ST_ACK;
			ST_ACK: begin
				if (strobe_off)
					state_next = ST_IDLE;
			end
			ST_CMRD: state_next = cm_switch ? ST_DMRD : ST_PUSH;
			ST_DMRD: state_next = ST_PUSH;
			ST_PUSH: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	// host answer data
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			rdata_reg <= '0;
			rd_reg <= 1'b0;
		end else if (host_take) begin
			rd_reg <= rw_q;
			rdata_reg <= mem_space ? '0 : reg_rdata;
		end else if (state_reg == ST_HRD) begin
			if (sel == SEL_DM)
				rdata_reg <= HD_W'(dm_if.rdata);
			else if (sel == SEL_CML)
				rdata_reg <= cml_if.rdata;
			else
				rdata_reg <= cmh_if.rdata;
		end
	end

	assign host_data_out = rdata_reg;
	assign host_data_oe = (state_reg == ST_ACK) && rd_reg;
	assign host_ack_n = state_reg != ST_ACK;

	// frame bank: constant delay reads the finished previous frame
	always_ff @(posedge ref_clk) begin
		if (!nrst)
			bank_reg <= 1'b0;
		else if (frame_start)
			bank_reg <= !bank_reg;
	end

	// per-request work registers
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			wk_stream_reg <= '0;
			wk_chan_reg <= '0;
			cml_keep_reg <= '0;
			cmh_keep_reg <= '0;
			wk_byte_reg <= '0;
			wk_drive_reg <= 1'b0;
		end else if (state_reg == ST_IDLE && req_fire) begin
			wk_stream_reg <= req_stream;
			wk_chan_reg <= req_channel;
		end else if (state_reg == ST_CMRD) begin
			cml_keep_reg <= cml_if.rdata;
			cmh_keep_reg <= cmh_if.rdata;
			wk_byte_reg <= '0;
			wk_drive_reg <= cm_switch;
			if (cm_on && cml_if.rdata[CML_MODE]) begin
				case (cml_if.rdata[CML_PCC +: 2])
					PCC_MSG: begin
						wk_byte_reg <= xlate(
							cml_if.rdata[CML_MSG +: BYTE_W],
							cml_if.rdata, cmh_if.rdata);
						wk_drive_reg <= 1'b1;
					end
					PCC_BER: begin
						wk_byte_reg <= BER_TEST_BYTE; // untranslated
						wk_drive_reg <= 1'b1;
					end
					default: wk_drive_reg <= 1'b0; // tristate, reserved
				endcase
			end
		end else if (state_reg == ST_DMRD) begin
			wk_byte_reg <= xlate(dm_if.rdata, cml_keep_reg,
				cmh_keep_reg);
		end
	end

	// output buffer; a stalled receiver holds the sequencer in idle
	assign push = state_reg == ST_PUSH;
	assign pop = out_valid && out_ready;
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			for (int i = 0; i < BUF_DEPTH; i++)
				buf_mem[i] <= '0;
		end else begin
			if (push) begin
				buf_mem[wr_ptr_reg] <= {wk_drive_reg, wk_byte_reg};
				wr_ptr_reg <= wr_ptr_reg + PW'(1);
			end
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + PW'(1);
			if (push && !pop)
				count_reg <= count_reg + (PW+1)'(1);
			else if (pop && !push)
				count_reg <= count_reg - (PW+1)'(1);
		end
	end

	assign out_valid = count_reg != '0;
	assign {out_drive, out_byte} = buf_mem[rd_ptr_reg];

	// error receiver window for the arriving byte
	always_comb begin
		ber_cap = rate_channels(socr_reg[in_stream][SOCR_RATE +: 4]);
		ber_len = (brlr_reg[in_stream] > ber_cap) ? ber_cap
			: brlr_reg[in_stream];
		ber_off = {1'b0, in_channel} - {1'b0, brsr_reg[in_stream]};
		ber_cmp = in_valid && ims_reg && brcr_reg[in_stream][BRCR_START]
			&& !brcr_reg[in_stream][BRCR_CLR]
			&& (in_channel >= brsr_reg[in_stream])
			&& (ber_off < ber_len);
		ber_step = prbs_step8(prbs_reg[in_stream]);
		ber_sum = {1'b0, err_reg[in_stream]}
			+ 17'(popcount8(in_byte ^ ber_step[BYTE_W-1:0]));
	end

	// error receivers: pattern state and saturating counters
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			for (int i = 0; i < STREAMS; i++) begin
				prbs_reg[i] <= PRBS_SEED;
				err_reg[i] <= '0;
			end
		end else begin
			for (int i = 0; i < STREAMS; i++) begin
				if (brcr_reg[i][BRCR_CLR])
					err_reg[i] <= '0;
				if (!brcr_reg[i][BRCR_START])
					prbs_reg[i] <= PRBS_SEED;
			end
			if (ber_cmp) begin
				prbs_reg[in_stream] <= ber_step[BYTE_W +: PRBS_W];
				err_reg[in_stream] <= ber_sum[HD_W] ? ERR_MAX
					: ber_sum[HD_W-1:0];
			end
		end
	end
endmodule
`default_nettype wire

// file: rtl/tsw_mem.sv
`timescale 1ns/10ps
`default_nettype none
module tsw_mem #(
	parameter int AW = 12,
	parameter int DW = 16
) (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic nrst,
	// access port
	tsw_mem_if.mem    port
);
	logic [DW-1:0] ram [2**AW]; // contents are not reset
	logic [DW-1:0] rdata_reg;   // registered read data

	// write port
	always_ff @(posedge ref_clk) begin
		if (port.we)
			ram[port.waddr] <= port.wdata;
	end

	// read port, old data on a same-address collision
	always_ff @(posedge ref_clk) begin
		if (!nrst)
			rdata_reg <= '0;
		else if (port.re)
			rdata_reg <= ram[port.raddr];
	end

	assign port.rdata = rdata_reg;
endmodule
`default_nettype wire

// file: rtl/tsw_mem_if.sv
`timescale 1ns/10ps
`default_nettype none
// one write port and one registered read port
interface tsw_mem_if #(parameter int AW = 12, parameter int DW = 16);
	logic          we;    // write strobe
	logic [AW-1:0] waddr; // write address
	logic [DW-1:0] wdata; // write data
	logic          re;    // read strobe
	logic [AW-1:0] raddr; // read address
	logic [DW-1:0] rdata; // read data, one cycle after re
	modport mem (input we, waddr, wdata, re, raddr, output rdata);
	modport user (output we, waddr, wdata, re, raddr, input rdata);
endinterface
`default_nettype wire

// file: rtl/tsw_pkg.sv
// How it works
// - top address bit picks memory or registers
// - control low bits pick data, cm low, high
// - channel index limited by stream rate
// - entry mode bit clear means channel switching
// - switching takes source channel and stream fields
// - entry bit fourteen picks constant or variable delay
// - mode bit set: special mode, message byte
// - output code: tristate, message, test, reserved
// - differing law codes translate (not voice codes 2 and 3), equal codes pass
// - voice/data bit picks companding or inversion schemes
// - translation only for switched and message channels
// - clear bit holds error counter at zero
// - start bit runs the stream error receiver
// - comparison begins at programmed start channel
// - error count readable as sixteen bits
// - law code decode table for voice and data
`default_nettype none
package tsw_pkg;
	localparam int STREAMS = 16;        // serial streams
	localparam int ST_W    = 4;         // stream number width
	localparam int CH_W    = 8;         // channel number width
	localparam int HA_W    = 14;        // host address width
	localparam int HD_W    = 16;        // host data width
	localparam int CM_AW   = ST_W + CH_W;
	localparam int DM_AW   = CM_AW + 1; // extra bit is the frame bank
	localparam int BYTE_W  = 8;
	// host address layout
	localparam int MEM_SPACE_BIT = 13;
	localparam int ADDR_ST_LSB   = 8;
	localparam int ADDR_ST_HI    = 12;  // must be zero, only 16 streams
	localparam logic [HA_W-1:0] IDX_MASK       = 14'h000F;
	localparam logic [HA_W-1:0] REG_CTRL       = 14'h0000;
	localparam logic [HA_W-1:0] REG_IMS        = 14'h0001;
	localparam logic [HA_W-1:0] REG_SOCR_BASE  = 14'h0200;
	localparam logic [HA_W-1:0] REG_BRSR_BASE  = 14'h0300;
	localparam logic [HA_W-1:0] REG_BRLR_BASE  = 14'h0320;
	localparam logic [HA_W-1:0] REG_BRCR_BASE  = 14'h0340;
	localparam logic [HA_W-1:0] REG_BRER_BASE  = 14'h0360;
	// control and interface mode fields
	localparam int CTRL_SEL_LSB  = 0;
	localparam int CTRL_VARIABLE_DELAY_ENABLE    = 2;
	localparam int CTRL_W        = 3;
	localparam int IMS_RXEN      = 0;
	localparam logic [1:0] SEL_DM  = 2'h0;
	localparam logic [1:0] SEL_CML = 2'h1;
	localparam logic [1:0] SEL_CMH = 2'h2;
	// connection memory low fields
	localparam int CML_MODE  = 0;
	localparam int CML_SCA   = 1;
	localparam int CML_SSA   = 9;
	localparam int CML_VC    = 14;
	localparam int CML_LAW_CONVERT_ENABLE  = 15;
	localparam int CML_PCC   = 1;
	localparam int CML_MSG   = 3;
	localparam logic [1:0] PCC_TRI = 2'h0;
	localparam logic [1:0] PCC_MSG = 2'h1;
	localparam logic [1:0] PCC_BER = 2'h2;
	// connection memory high fields
	localparam int CMH_OCL = 0;
	localparam int CMH_ICL = 2;
	localparam int CMH_VD  = 4;
	localparam logic [7:0] LAW_MASK_A    = 8'h55;
	localparam logic [7:0] LAW_MASK_MU   = 8'h7F;
	localparam logic [7:0] LAW_MASK_NONE = 8'h00;
	localparam logic [7:0] LAW_MASK_ALT  = 8'h55;
	localparam logic [7:0] LAW_MASK_IALT = 8'hAA;
	localparam logic [7:0] LAW_MASK_ALL  = 8'hFF;
	// stream output control fields
	localparam int SOCR_RATE = 0;
	localparam int SOCR_W    = 12;
	localparam logic [3:0] RATE_2M  = 4'h1;
	localparam logic [3:0] RATE_4M  = 4'h2;
	localparam logic [3:0] RATE_8M  = 4'h3;
	localparam logic [3:0] RATE_16M = 4'h4;
	localparam logic [8:0] CH_2M  = 9'h020;
	localparam logic [8:0] CH_4M  = 9'h040;
	localparam logic [8:0] CH_8M  = 9'h080;
	localparam logic [8:0] CH_16M = 9'h100;
	// error receiver fields
	localparam int BRCR_START = 0;
	localparam int BRCR_CLR   = 1;
	localparam int BRLR_W     = 9;
	localparam int PRBS_W     = 15;
	localparam logic [14:0] PRBS_SEED = 15'h7FFF;
	localparam logic [15:0] ERR_MAX   = 16'hFFFF;
	localparam logic [7:0]  BER_TEST_BYTE = 8'hFF;
	localparam int PIN_W = 3 + HA_W + HD_W;
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_HRD  = 6'b000010,
		ST_ACK  = 6'b000100,
		ST_CMRD = 6'b001000,
		ST_DMRD = 6'b010000,
		ST_PUSH = 6'b100000
	} tsw_state_e;

	// xor mask that turns a line code into the common form
	function automatic logic [7:0] law_mask(input logic vd,
		input logic [1:0] code);
		case ({vd, code})
			3'b000:  return LAW_MASK_A;
			3'b001:  return LAW_MASK_MU;
			3'b101:  return LAW_MASK_ALT;
			3'b110:  return LAW_MASK_IALT;
			3'b111:  return LAW_MASK_ALL;
			default: return LAW_MASK_NONE;
		endcase
	endfunction

	// equal codes cancel, so no translation happens
	function automatic logic [7:0] xlate(input logic [7:0] b,
		input logic [15:0] cml, input logic [15:0] cmh);
		if (!cml[CML_LAW_CONVERT_ENABLE])
			return b;
		return b ^ law_mask(cmh[CMH_VD], cmh[CMH_ICL +: 2])
			^ law_mask(cmh[CMH_VD], cmh[CMH_OCL +: 2]);
	endfunction

	// channels per frame for a rate code, zero when off
	function automatic logic [8:0] rate_channels(input logic [3:0] r);
		case (r)
			RATE_2M:  return CH_2M;
			RATE_4M:  return CH_4M;
			RATE_8M:  return CH_8M;
			RATE_16M: return CH_16M;
			default:  return 9'h000;
		endcase
	endfunction

	function automatic logic chan_ok(input logic [3:0] r,
		input logic [7:0] ch);
		return {1'b0, ch} < rate_channels(r);
	endfunction

	function automatic logic [3:0] popcount8(input logic [7:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < BYTE_W; i++)
			n = n + {3'h0, v[i]};
		return n;
	endfunction

	// eight steps of a 2^15-1 generator: {new state, byte}
	function automatic logic [22:0] prbs_step8(input logic [14:0] s);
		logic [14:0] st;
		logic [7:0]  b;
		st = s;
		b = 8'h00;
		for (int i = 0; i < BYTE_W; i++) begin
			b = {b[6:0], st[14] ^ st[13]};
			st = {st[13:0], st[14] ^ st[13]};
		end
		return {st, b};
	endfunction
endpackage
`default_nettype wire

// file: sim/tsw_conn_ctrl_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// host port and request path timing
module tsw_conn_ctrl_asserts (
	// clock, reset
	input wire logic ref_clk,
	input wire logic nrst,
	// host port
	input wire logic host_cs_n,
	input wire logic host_ds_n,
	input wire logic host_rw,
	input wire logic host_data_oe,
	input wire logic host_ack_n,
	// requests, results
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic out_drive
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// read data only under ack
	oe_under_ack_a: assert property (host_data_oe |-> !host_ack_n)
		else $error("data driven without ack");
	// ack needs a strobe that has stood
	ack_cause_a: assert property ($fell(host_ack_n)
		|-> !$past(host_ds_n, 4) && !$past(host_cs_n, 4))
		else $error("ack without strobe");
	// released strobe ends the ack
	ack_release_a: assert property (host_ds_n [*6] |-> host_ack_n)
		else $error("ack held too long");
	// writes never drive the bus
	write_quiet_a: assert property (!host_ack_n && !host_rw
		|-> !host_data_oe)
		else $error("write drives data");
	// host access blocks requests
	host_block_a: assert property (!host_ack_n |-> !req_ready)
		else $error("request taken during access");
	// taken request makes it busy
	req_busy_a: assert property (req_valid && req_ready
		|=> !req_ready)
		else $error("ready after take");
	// every request answers in bounded time
	req_answer_a: assert property (req_valid && req_ready
		|-> ##[1:6] out_valid)
		else $error("no result");
	// stalled result stands
	out_hold_a: assert property (out_valid && !out_ready
		|=> out_valid && $stable(out_drive))
		else $error("result lost in stall");
endmodule
bind tsw_conn_ctrl tsw_conn_ctrl_asserts tsw_conn_ctrl_asserts_i (
	.ref_clk, .nrst, .host_cs_n, .host_ds_n, .host_rw, .host_data_oe,
	.host_ack_n, .req_valid, .req_ready, .out_valid, .out_ready,
	.out_drive);
`default_nettype wire

// file: sim/tsw_conn_ctrl_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tsw_conn_ctrl_tb_top;
	import tsw_pkg::*;
	// clock, reset, host pins
	logic            ref_clk = 1'b0;
	logic            nrst = 1'b0;
	logic            host_cs_n, host_ds_n, host_rw, hang;
	logic            host_data_oe, host_ack_n;
	logic [HA_W-1:0] host_addr;
	logic [HD_W-1:0] host_data_in, host_data_out, q;
	// input bytes, requests
	logic            frame_start = 1'b0, in_valid = 1'b0;
	logic            req_valid = 1'b0, out_ready = 1'b0;
	logic            req_ready, out_valid, out_drive;
	logic [3:0]      in_stream = '0, req_stream = '0;
	logic [7:0]      in_channel = '0, in_byte = '0, req_channel = '0;
	logic [7:0]      out_byte;
	// law masks by {data bit, code}
	logic [7:0] mk [8] = '{LAW_MASK_A, LAW_MASK_MU, LAW_MASK_NONE,
		LAW_MASK_NONE, LAW_MASK_NONE, LAW_MASK_ALT, LAW_MASK_IALT,
		LAW_MASK_ALL};
	int miscompares = 0;
	int tests_run = 0;
	always #5 ref_clk = ~ref_clk;
	tsw_conn_ctrl tsw_conn_ctrl_i (.ref_clk, .nrst, .host_cs_n,
		.host_ds_n, .host_rw, .host_addr, .host_data_in, .host_data_out,
		.host_data_oe, .host_ack_n, .frame_start, .in_valid, .in_stream,
		.in_channel, .in_byte, .req_valid, .req_ready, .req_stream,
		.req_channel, .out_valid, .out_ready, .out_byte, .out_drive);
	tsw_host_model tsw_host_model_i (.ref_clk, .host_cs_n, .host_ds_n,
		.host_rw, .host_addr, .host_data_in, .host_ack_n, .host_data_out,
		.hang);
	task automatic chk(input string nm, input logic [15:0] s, e);
		tests_run++;
		if (s !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
			miscompares++;
		end
	endtask
	task automatic final_report();
		if (hang === 1'b1)
			miscompares++;
		$display("mismatches %0d checks %0d", miscompares, tests_run);
		if (miscompares == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic rd(input logic [HA_W-1:0] a, input logic [15:0] e);
		tsw_host_model_i.acc(1'b1, a, 16'h0000, q);
		chk($sformatf("word %h", a), q, e);
	endtask
	task automatic wr(input logic [HA_W-1:0] a, input logic [15:0] d);
		tsw_host_model_i.acc(1'b0, a, d, q);
	endtask
	// one request, held until taken
	task automatic put(input logic [3:0] s, input logic [7:0] c);
		int n = 0;
		@(posedge ref_clk);
		{req_valid, req_stream, req_channel} <= {1'b1, s, c};
		do begin
			@(negedge ref_clk);
			n++;
		end while (req_ready !== 1'b1 && n < 50);
		if (n >= 50)
			miscompares++;
		@(posedge ref_clk);
		req_valid <= 1'b0;
	endtask
	// wait for a result, compare, pop it
	task automatic get(input logic [7:0] b, input logic d);
		int n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (out_valid !== 1'b1 && n < 50);
		if (n >= 50)
			miscompares++;
		chk("out_byte", {8'h00, out_byte}, {8'h00, b});
		chk("out_drive", {15'h0000, out_drive}, {15'h0000, d});
		@(posedge ref_clk);
		out_ready <= 1'b1;
		@(posedge ref_clk);
		out_ready <= 1'b0;
	endtask
	// an input byte, or a frame pulse when f is set
	task automatic feed(input logic f, input logic [3:0] s,
		input logic [7:0] c, b);
		@(posedge ref_clk);
		{frame_start, in_valid, in_stream, in_channel, in_byte} <=
			{f, !f, s, c, b};
		@(posedge ref_clk);
		{frame_start, in_valid} <= 2'b00;
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		nrst <= 1'b1;
		wr(REG_SOCR_BASE, 16'h0004);
		rd(REG_SOCR_BASE, 16'h0004);
		wr(REG_SOCR_BASE + 14'h0002, 16'h0001);
		wr(REG_BRER_BASE, 16'hBEEF);
		rd(REG_BRER_BASE, 16'h0000);
		rd(14'h0100, 16'h0000);
		wr(REG_CTRL, 16'h0001);
		wr(14'h2220, 16'h1234);
		rd(14'h2220, 16'h0000);
		wr(14'h221F, 16'h1234);
		rd(14'h221F, 16'h1234);
		// message, tristate, test pattern; stall fills buffer
		wr(14'h2005, 16'h052B);
		wr(14'h2006, 16'h0001);
		wr(14'h2007, 16'h0005);
		put(4'h0, 8'h05);
		put(4'h0, 8'h06);
		repeat (6) @(negedge ref_clk);
		chk("req_ready", {15'h0000, req_ready}, 16'h0000);
		get(8'hA5, 1'b1);
		get(8'h00, 1'b0);
		put(4'h0, 8'h07);
		get(BER_TEST_BYTE, 1'b1);
		// law codes: high words first, then enable
		wr(REG_CTRL, 16'h0002);
		for (int i = 0; i < 8; i++)
			wr(14'h2010 + 14'(i), {11'h000, 3'(i), 2'b00});
		wr(14'h200D, 16'h001C);
		wr(REG_CTRL, 16'h0001);
		wr(14'h200D, 16'h8005);
		put(4'h0, 8'h0D);
		get(BER_TEST_BYTE, 1'b1);
		for (int i = 0; i < 8; i++) begin
			wr(14'h2010 + 14'(i), 16'h81E3);
			put(4'h0, 8'h10 + 8'(i));
			get(8'h3C ^ mk[i] ^ mk[i & 4], 1'b1);
		end
		// constant delay reads last frame, variable this one
		feed(1'b0, 4'h1, 8'h03, 8'h5A);
		feed(1'b1, 4'h0, 8'h00, 8'h00);
		wr(14'h2008, 16'h0206);
		put(4'h0, 8'h08);
		get(8'h5A, 1'b1);
		wr(REG_CTRL, 16'h0005);
		feed(1'b0, 4'h1, 8'h04, 8'h3B);
		wr(14'h2009, 16'h4208);
		put(4'h0, 8'h09);
		get(8'h3B, 1'b1);
		// error receiver: window is channels 1 and 2
		wr(REG_IMS, 16'h0001);
		wr(REG_BRSR_BASE, 16'h0001);
		wr(REG_BRLR_BASE, 16'h0002);
		wr(REG_BRCR_BASE, 16'h0001);
		feed(1'b0, 4'h0, 8'h00, 8'hFF);
		feed(1'b0, 4'h0, 8'h01, 8'hFF);
		feed(1'b0, 4'h0, 8'h02, 8'h0F);
		rd(REG_BRER_BASE, 16'h000B);
		wr(REG_BRCR_BASE, 16'h0003);
		rd(REG_BRER_BASE, 16'h0000);
		wr(REG_BRCR_BASE, 16'h0000);
		final_report();
	end
	// hang guard
	initial begin
		repeat (100000) @(posedge ref_clk);
		miscompares++;
		final_report();
	end
endmodule
`default_nettype wire

// file: sim/tsw_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// host processor, one strobed access at a time
module tsw_host_model (
	// clock
	input wire logic                     ref_clk,
	// bus pins
	output logic                         host_cs_n,
	output logic                         host_ds_n,
	output logic                         host_rw,
	output logic [tsw_pkg::HA_W-1:0]     host_addr,
	output logic [tsw_pkg::HD_W-1:0]     host_data_in,
	input wire logic                     host_ack_n,
	input wire logic [tsw_pkg::HD_W-1:0] host_data_out,
	// ack never came or never left
	output logic                         hang
);
	import tsw_pkg::*;
	initial begin
		{host_cs_n, host_ds_n, host_rw} = 3'h7;
		host_addr = '0;
		host_data_in = '0;
		hang = 1'b0;
	end
	// strobe stands until ack, then is released
	task automatic acc(input logic rw, input logic [HA_W-1:0] a,
		input logic [HD_W-1:0] d, output logic [HD_W-1:0] q);
		int n = 0;
		@(posedge ref_clk);
		{host_cs_n, host_ds_n, host_rw, host_addr} <= {2'b00, rw, a};
		host_data_in <= rw ? ~host_data_in : d; // inverted old value on reads
		while (host_ack_n !== 1'b0 && n < 60) begin
			@(negedge ref_clk);
			n++;
		end
		q = host_data_out;
		@(posedge ref_clk);
		{host_cs_n, host_ds_n} <= 2'b11;
		host_data_in <= ~host_data_in;
		while (host_ack_n !== 1'b1 && n < 120) begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= 60)
			hang = 1'b1;
	endtask
endmodule
`default_nettype wire
